// File: rtl/mdk_map.vh
// Register map, field layout and reset values of the monitor and key register bank.
// Assumes inclusion by bare name; offsets are word indices, byte address is four times the index.
`ifndef MDK_MAP_VH
`define MDK_MAP_VH
////////////////////////////////////////////////////////////////////////////////
`define MDK_IDX_W 11
`define MDK_IDX_MON2 11'h0f6
`define MDK_IDX_KEY 11'h0f8
`define MDK_IDX_STAT 11'h0fa
`define MDK_IDX_STATE 11'h18e
`define MDK_IDX_TACH_SPD 11'h194
`define MDK_IDX_BETA_V 11'h400
`define MDK_IDX_BUS_I 11'h40c
`define MDK_IDX_PH1_I 11'h444
`define MDK_IDX_PH2_I 11'h446
`define MDK_IDX_PH3_I 11'h448
`define MDK_IDX_AMP_G 11'h46c
`define MDK_IDX_VOLT_G 11'h477
`define MDK_IDX_VSUP 11'h47c
`define MDK_IDX_PH1_V 11'h484
`define MDK_IDX_PH2_V 11'h486
`define MDK_IDX_PH3_V 11'h488
`define MDK_IDX_ANG_SIN 11'h4bc
`define MDK_IDX_ANG_COS 11'h4be
`define MDK_IDX_ALPHA_I 11'h4dc
`define MDK_IDX_BETA_I 11'h4de
`define MDK_IDX_ALPHA_V 11'h4e0
`define MDK_IDX_DAX_I 11'h4ec
`define MDK_IDX_QAX_I 11'h4ee
`define MDK_IDX_DAX_V 11'h4f0
`define MDK_IDX_QAX_V 11'h4f2
`define MDK_IDX_ALN_IREF 11'h52a
`define MDK_IDX_OL_SREF 11'h540
`define MDK_IDX_OL_IREF 11'h550
`define MDK_IDX_CL_SREF 11'h5d2
`define MDK_IDX_CL_DREF 11'h612
`define MDK_IDX_CL_QREF 11'h614
`define MDK_IDX_SPIN_ST 11'h6ae
`define MDK_IDX_SPIN_SPD 11'h6b8
`define MDK_IDX_POS_ST 11'h6ea
`define MDK_IDX_POS_ANG 11'h72e
`define MDK_IDX_DAX_E 11'h772
`define MDK_IDX_QAX_E 11'h774
`define MDK_IDX_EST_SPD 11'h782
`define MDK_IDX_EST_ANG 11'h786
////////////////////////////////////////////////////////////////////////////////
`define MDK_VAR_SLOTS 36
`define MDK_STATE_W 16
`define MDK_MON2_W 23
`define MDK_MON2_RST 23'h040000
`define MDK_POW2_LSB 19
`define MDK_FRAC_LSB 15
`define MDK_SE_BIT 14
`define MDK_PTR_W 14
`define MDK_KEY_W 15
`define MDK_KEY_RST 15'h0000
`define MDK_VAR_FRAC_BITS 27
`define MDK_SCALE_BITS 3
`endif

// File: rtl/mdk_var_mem.v
// Small memory holding the live algorithm variables, one write and two registered read ports.
// Assumes the writer and both readers run on the same clock as the register bank.
`timescale 1ns/1ps
`default_nettype none
module mdk_var_mem #(
  parameter DW = 32,
  parameter DEPTH = 36,
  parameter AW = 6
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] a_addr,
  output reg [DW-1:0] a_data_ff,
  input wire [AW-1:0] b_addr,
  output reg [DW-1:0] b_data_ff
);
  reg [DW-1:0] mem [0:DEPTH-1];
  // Array has no reset, so out-of-range reads return zero rather than stale cells.
  always @(posedge clk) begin
    if (ce && wr_en && (wr_addr < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      a_data_ff <= {DW{1'b0}};
      b_data_ff <= {DW{1'b0}};
    end else if (ce) begin
      a_data_ff <= (a_addr < DEPTH) ? mem[a_addr] : {DW{1'b0}};
      b_data_ff <= (b_addr < DEPTH) ? mem[b_addr] : {DW{1'b0}};
    end
  end
endmodule
`default_nettype wire

// File: rtl/mdk_regs.v
// Monitor channel two control, configuration memory key and algorithm variable map, as an APB slave.
// Assumes one clock, an APB master on the same clock, and an algorithm core writing variable slots.
//
// Summary of operation
// - With fraction scale zero, the variable is multiplied by two to the power of the multiplier field.
// - A nonzero fraction scale code multiplies the variable by code over eight.
// - Fraction scale zero treats the variable as an enumerated value of at most 31.
// - The single-ended select picks bipolar around mid-scale when clear and unipolar when set.
// - In unipolar mode the full three-volt span equals base value times one over the scale.
// - In bipolar mode the half span of 1.5 V around mid-scale equals base value over the scale.
// - Variables arrive in base units with 27 fraction bits, so the base value is one full unit.
// - A 14-bit read-write variable pointer selects the variable shown on monitor output two.
// - The security register holds a 15-bit read-write user key in its low bits.
// - Configuration memory access is granted only when the user key matches the stored lock key.
// - The security register resets to zero and its top bit reads as zero.
// - The controller state register is 16 bits wide, idle at zero up to 18h.
`timescale 1ns/1ps
`default_nettype none
`include "mdk_map.vh"
module mdk_regs #(
  parameter DAC_W = 12
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire var_wr_en,
  input wire [5:0] var_wr_slot,
  input wire [31:0] var_wr_data,
  input wire [14:0] lock_key,
  output wire [DAC_W-1:0] monitor_output_two,
  output wire cfg_unlocked
);

////////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam integer SHIFT_U = `MDK_VAR_FRAC_BITS + `MDK_SCALE_BITS - DAC_W;
  localparam [47:0] DAC_MAX = (48'h1 << DAC_W) - 48'h1;
  localparam [47:0] DAC_MID = 48'h1 << (DAC_W - 1);

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] prdata_ff;
  reg [31:0] nxt_prdata;
  reg pready_ff;
  reg pslverr_ff;
  reg nxt_pslverr;
  reg [`MDK_MON2_W-1:0] mon2_ff;
  reg [`MDK_MON2_W-1:0] nxt_mon2;
  reg [`MDK_KEY_W-1:0] key_ff;
  reg [`MDK_KEY_W-1:0] nxt_key;
  reg unlocked_ff;
  reg [DAC_W-1:0] mon_code_ff;
  reg [DAC_W-1:0] nxt_mon_code;
  reg mon_valid_ff;
  reg mon_clamp_ff;
  reg nxt_mon_clamp;

  wire [31:0] var_rd_a;
  wire [31:0] var_rd_b;
  wire [`MDK_IDX_W-1:0] bus_idx;
  wire [6:0] bus_slot;
  wire [6:0] mon_slot;
  wire [31:0] wmask;
  wire [3:0] mon2_pow2_multiplier;
  wire [3:0] mon2_fraction_scale;
  wire mon2_single_ended_select;
  wire [`MDK_PTR_W-1:0] mon2_variable_pointer;
  wire sel_mon2;
  wire sel_key;
  wire sel_stat;
  wire wr_fire;

////////////////////////////////////////////////////////////////////////////////
  // Maps a word index onto a variable slot; bit 6 marks a valid slot.
  // Index comparisons are exact, so unlisted offsets inside the map fall through to no slot.
  function [6:0] slot_of;
    input [`MDK_IDX_W-1:0] idx;
    begin
      case (idx)
        `MDK_IDX_STATE: slot_of = {1'b1, 6'd0};
        `MDK_IDX_TACH_SPD: slot_of = {1'b1, 6'd1};
        `MDK_IDX_BETA_V: slot_of = {1'b1, 6'd2};
        `MDK_IDX_BUS_I: slot_of = {1'b1, 6'd3};
        `MDK_IDX_PH1_I: slot_of = {1'b1, 6'd4};
        `MDK_IDX_PH2_I: slot_of = {1'b1, 6'd5};
        `MDK_IDX_PH3_I: slot_of = {1'b1, 6'd6};
        `MDK_IDX_AMP_G: slot_of = {1'b1, 6'd7};
        `MDK_IDX_VOLT_G: slot_of = {1'b1, 6'd8};
        `MDK_IDX_VSUP: slot_of = {1'b1, 6'd9};
        `MDK_IDX_PH1_V: slot_of = {1'b1, 6'd10};
        `MDK_IDX_PH2_V: slot_of = {1'b1, 6'd11};
        `MDK_IDX_PH3_V: slot_of = {1'b1, 6'd12};
        `MDK_IDX_ANG_SIN: slot_of = {1'b1, 6'd13};
        `MDK_IDX_ANG_COS: slot_of = {1'b1, 6'd14};
        `MDK_IDX_ALPHA_I: slot_of = {1'b1, 6'd15};
        `MDK_IDX_BETA_I: slot_of = {1'b1, 6'd16};
        `MDK_IDX_ALPHA_V: slot_of = {1'b1, 6'd17};
        `MDK_IDX_DAX_I: slot_of = {1'b1, 6'd18};
        `MDK_IDX_QAX_I: slot_of = {1'b1, 6'd19};
        `MDK_IDX_DAX_V: slot_of = {1'b1, 6'd20};
        `MDK_IDX_QAX_V: slot_of = {1'b1, 6'd21};
        `MDK_IDX_ALN_IREF: slot_of = {1'b1, 6'd22};
        `MDK_IDX_OL_SREF: slot_of = {1'b1, 6'd23};
        `MDK_IDX_OL_IREF: slot_of = {1'b1, 6'd24};
        `MDK_IDX_CL_SREF: slot_of = {1'b1, 6'd25};
        `MDK_IDX_CL_DREF: slot_of = {1'b1, 6'd26};
        `MDK_IDX_CL_QREF: slot_of = {1'b1, 6'd27};
        `MDK_IDX_SPIN_ST: slot_of = {1'b1, 6'd28};
        `MDK_IDX_SPIN_SPD: slot_of = {1'b1, 6'd29};
        `MDK_IDX_POS_ST: slot_of = {1'b1, 6'd30};
        `MDK_IDX_POS_ANG: slot_of = {1'b1, 6'd31};
        `MDK_IDX_DAX_E: slot_of = {1'b1, 6'd32};
        `MDK_IDX_QAX_E: slot_of = {1'b1, 6'd33};
        `MDK_IDX_EST_SPD: slot_of = {1'b1, 6'd34};
        `MDK_IDX_EST_ANG: slot_of = {1'b1, 6'd35};
        default: slot_of = 7'h00;
      endcase
    end
  endfunction

////////////////////////////////////////////////////////////////////////////////
  assign bus_idx = paddr[12:2];
  assign bus_slot = (paddr[1:0] == 2'b00) ? slot_of(bus_idx) : 7'h00;
  // Pointer bits above the index width must be zero to name a variable.
  assign mon_slot = (mon2_variable_pointer[13:11] == 3'b000) ?
                    slot_of(mon2_variable_pointer[10:0]) : 7'h00;

  assign mon2_pow2_multiplier = mon2_ff[`MDK_POW2_LSB+3:`MDK_POW2_LSB];
  assign mon2_fraction_scale = mon2_ff[`MDK_FRAC_LSB+3:`MDK_FRAC_LSB];
  assign mon2_single_ended_select = mon2_ff[`MDK_SE_BIT];
  assign mon2_variable_pointer = mon2_ff[`MDK_PTR_W-1:0];

  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Decoded register selects; only word-aligned addresses can hit a register.
  assign sel_mon2 = (paddr[1:0] == 2'b00) && (bus_idx == `MDK_IDX_MON2);
  assign sel_key = (paddr[1:0] == 2'b00) && (bus_idx == `MDK_IDX_KEY);
  assign sel_stat = (paddr[1:0] == 2'b00) && (bus_idx == `MDK_IDX_STAT);
  // A write fires only on the edge that ends the answer cycle, and only when no error was flagged.
  assign wr_fire = (state_ff == ST_DONE) && psel && penable && pwrite && !pslverr_ff;

////////////////////////////////////////////////////////////////////////////////

  mdk_var_mem #(
    .DW(32),
    .DEPTH(`MDK_VAR_SLOTS),
    .AW(6)
  ) u_var_mem (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_en(var_wr_en),
    .wr_addr(var_wr_slot),
    .wr_data(var_wr_data),
    .a_addr(bus_slot[5:0]),
    .a_data_ff(var_rd_a),
    .b_addr(mon_slot[5:0]),
    .b_data_ff(var_rd_b)
  );

////////////////////////////////////////////////////////////////////////////////
  // Every access takes the same three access cycles, so the memory read port settles before the answer.
  // The master keeps psel and penable up until pready; an access cannot be aborted.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (psel && penable) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Read data and error are formed at the end of the fetch cycle.
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_pslverr = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      nxt_pslverr = 1'b1;
    end else if (bus_idx == `MDK_IDX_MON2) begin
      // Scaling and mode fields are write-only and read back as zero.
      nxt_prdata = {18'h00000, mon2_variable_pointer};
    end else if (bus_idx == `MDK_IDX_KEY) begin
      nxt_prdata = {17'h00000, key_ff};
    end else if (bus_idx == `MDK_IDX_STAT) begin
      // Status is read-only; a write to it is refused like a variable write.
      nxt_prdata = {29'h00000000, mon_clamp_ff, mon_valid_ff, unlocked_ff};
      nxt_pslverr = pwrite;
    end else if (bus_slot[6]) begin
      if (bus_slot[5:0] == 6'd0) begin
        nxt_prdata = {16'h0000, var_rd_a[`MDK_STATE_W-1:0]};
      end else begin
        nxt_prdata = var_rd_a;
      end
      nxt_pslverr = pwrite;
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  // Writes land on the edge at which the master sees pready.
  always @* begin
    nxt_mon2 = mon2_ff;
    nxt_key = key_ff;
    if (wr_fire) begin
      // Byte strobes let software change the low pointer byte without touching the scaling fields.
      if (sel_mon2) begin
        nxt_mon2 = (mon2_ff & ~wmask[`MDK_MON2_W-1:0]) |
                   (pwdata[`MDK_MON2_W-1:0] & wmask[`MDK_MON2_W-1:0]);
      end
      if (sel_key) begin
        nxt_key = (key_ff & ~wmask[`MDK_KEY_W-1:0]) |
                  (pwdata[`MDK_KEY_W-1:0] & wmask[`MDK_KEY_W-1:0]);
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      mon2_ff <= `MDK_MON2_RST;
      key_ff <= `MDK_KEY_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
      mon2_ff <= nxt_mon2;
      key_ff <= nxt_key;
    end
  end

  // The answer flops are cleared outside the answer cycle, so prdata reads zero whenever pready is low.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == ST_FETCH) begin
        prdata_ff <= nxt_prdata;
        pslverr_ff <= nxt_pslverr;
        pready_ff <= 1'b1;
      end else begin
        prdata_ff <= 32'h00000000;
        pslverr_ff <= 1'b0;
        pready_ff <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // A zero key never unlocks, so clearing the key always relocks the memory.
  // The stored lock key arrives on this clock, so it is compared without a synchroniser.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      unlocked_ff <= 1'b0;
    end else if (ce) begin
      unlocked_ff <= (key_ff != `MDK_KEY_RST) && (key_ff == lock_key);
    end
  end

////////////////////////////////////////////////////////////////////////////////
  // Variables carry 27 fraction bits, so one base value maps to 2^27 whatever its unit.
  // Unipolar: the full span of 2^DAC_W codes stands for base over scale, so
  // code = v * f / 8 * 2^DAC_W / 2^27, which is the shift by SHIFT_U.
  // Bipolar: half the span stands for base over scale, so one more shift, then mid-scale.
  // The product is kept in 48 bits so fifteen eighths of a full-scale variable cannot overflow.
  reg signed [47:0] sc_var;
  reg signed [47:0] sc_w;
  always @* begin
    sc_var = {{16{var_rd_b[31]}}, var_rd_b};
    nxt_mon_clamp = 1'b0;
    if (mon2_fraction_scale == 4'h0) begin
      // Enumerated values above 31 are held at 31 before the power-of-two gain.
      // Negative enumerated values are not held and may saturate at the bottom of the span.
      if (sc_var > 48'sd31) begin
        sc_var = 48'sd31;
      end
      sc_w = sc_var <<< mon2_pow2_multiplier;
      if (!mon2_single_ended_select) begin
        sc_w = sc_w + $signed(DAC_MID);
      end
    end else if (mon2_single_ended_select) begin
      sc_w = (sc_var * $signed({44'h0, mon2_fraction_scale})) >>> SHIFT_U;
    end else begin
      sc_w = ((sc_var * $signed({44'h0, mon2_fraction_scale})) >>> (SHIFT_U + 1)) +
             $signed(DAC_MID);
    end
    if (!mon_valid_ff) begin
      sc_w = mon2_single_ended_select ? 48'sd0 : $signed(DAC_MID);
    end
    // Out-of-span values saturate rather than wrap, which keeps the monitor trace readable.
    if (sc_w < 48'sd0) begin
      nxt_mon_code = {DAC_W{1'b0}};
      nxt_mon_clamp = 1'b1;
    end else if (sc_w > $signed(DAC_MAX)) begin
      nxt_mon_code = {DAC_W{1'b1}};
      nxt_mon_clamp = 1'b1;
    end else begin
      nxt_mon_code = sc_w[DAC_W-1:0];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_valid_ff <= 1'b0;
      mon_code_ff <= {DAC_W{1'b0}};
      mon_clamp_ff <= 1'b0;
    end else if (ce) begin
      // The code lags a pointer or variable change by two edges: memory read, then code register.
      mon_valid_ff <= mon_slot[6];
      mon_code_ff <= nxt_mon_code;
      mon_clamp_ff <= nxt_mon_clamp;
    end
  end

////////////////////////////////////////////////////////////////////////////////
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign monitor_output_two = mon_code_ff;
  assign cfg_unlocked = unlocked_ff;
endmodule
`default_nettype wire

// File: test/mdk_regs_checker.sv
// Concurrent checks on the ports of the monitor and key register bank.
// Assumes one clock and the full byte strobe on the key writes that the key checks watch.
`timescale 1ns/1ps
`default_nettype none
module mdk_regs_checker #(
  parameter DAC_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic var_wr_en,
  input wire logic [5:0] var_wr_slot,
  input wire logic [31:0] var_wr_data,
  input wire logic [14:0] lock_key,
  input wire logic [DAC_W-1:0] monitor_output_two,
  input wire logic cfg_unlocked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire acc_done = psel && penable && pready;
  wire key_wr = acc_done && pwrite && paddr == 13'h3e0 && pstrb == 4'hf;
  ////////////////////////////////////////////////////////////////////////////////
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_RDY_LAT: assert property (ce && psel && penable && !$past(psel && penable) |-> ##2 pready)
    else $error("pready latency wrong");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_VAR_RO: assert property (acc_done && pwrite && paddr >= 13'h638 |-> pslverr)
    else $error("variable write accepted");
  AST_PTR_READ: assert property (acc_done && !pwrite && paddr == 13'h3d8 |-> prdata[31:14] == 18'h0)
    else $error("monitor control write fields readable");
  AST_KEY_TOP: assert property (acc_done && !pwrite && paddr == 13'h3e0 |-> prdata[31:15] == 17'h0)
    else $error("security top bits not zero");
  AST_KEY_MATCH: assert property (key_wr && pwdata[14:0] == lock_key && lock_key != 15'h0
    ##1 $stable(lock_key) [*2] |-> cfg_unlocked) else $error("matching key did not unlock");
  AST_KEY_MISS: assert property (key_wr && pwdata[14:0] != lock_key
    ##1 $stable(lock_key) [*2] |-> !cfg_unlocked) else $error("wrong key left memory unlocked");
  AST_RST_LOCKED: assert property ($past(rst) |-> !cfg_unlocked)
    else $error("unlocked right after reset");
  AST_LOCK_CHG: assert property (cfg_unlocked && $changed(lock_key) |=> !cfg_unlocked)
    else $error("stale key kept memory unlocked");
endmodule
bind mdk_regs mdk_regs_checker #(.DAC_W(DAC_W)) u_chk (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .var_wr_en(var_wr_en), .var_wr_slot(var_wr_slot), .var_wr_data(var_wr_data),
  .lock_key(lock_key), .monitor_output_two(monitor_output_two), .cfg_unlocked(cfg_unlocked)
);
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the monitor and key register bank, driven over APB.
// Assumes variables are loaded by slot and the stored lock key sits on lock_key.
`timescale 1ns/1ps
`default_nettype none
`include "mdk_map.vh"
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module tb_top;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, var_wr_en = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h0, var_wr_data = 32'h0;
  logic [5:0] var_wr_slot = 6'h00;
  logic [14:0] lock_key = 15'h1234;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, cfg_unlocked;
  logic [11:0] mon_out, e;
  int num_errors = 0, num_checks = 0, cycles = 0;
  mdk_regs #(.DAC_W(12)) uut (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .var_wr_en(var_wr_en), .var_wr_slot(var_wr_slot), .var_wr_data(var_wr_data),
    .lock_key(lock_key), .monitor_output_two(mon_out), .cfg_unlocked(cfg_unlocked)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [`MDK_IDX_W-1:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [`MDK_IDX_W-1:0] idx, input logic [31:0] ex, input string nm);
    apb(1'b0, idx, 32'h0);
    `CHK(nm, ex, rdata)
    `CHK("pslverr", 1'b0, rerr)
  endtask
  task automatic vw(input logic [5:0] s, input logic [31:0] d);
    @(posedge clk);
    var_wr_en <= 1'b1;
    var_wr_slot <= s;
    var_wr_data <= d;
    @(posedge clk);
    var_wr_en <= 1'b0;
  endtask
  // Codes past the DAC range are expected to saturate at full scale.
  task automatic mon(input logic [3:0] m, input logic [3:0] f, input logic se, input logic [13:0] p, input int ex);
    apb(1'b1, `MDK_IDX_MON2, {9'h0, m, f, se, p});
    repeat (3) @(posedge clk);
    e = (ex > 4095) ? 12'hfff : ex[11:0];
    `CHK("monitor code", e, mon_out)
  endtask
  task automatic unl(input logic ex, input string nm);
    repeat (3) @(posedge clk);
    `CHK(nm, ex, cfg_unlocked)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("monitor after reset", 12'h800, mon_out)
    rd(`MDK_IDX_KEY, 32'h0, "key reset");
    rd(`MDK_IDX_MON2, 32'h0, "mon2 reset");
    apb(1'b1, `MDK_IDX_KEY, 32'h1234);
    unl(1'b1, "unlock");
    rd(`MDK_IDX_KEY, 32'h1234, "key readback");
    apb(1'b1, `MDK_IDX_KEY, 32'hffff_ffff);
    rd(`MDK_IDX_KEY, 32'h7fff, "key top bit");
    pstrb <= 4'h1;
    apb(1'b1, `MDK_IDX_KEY, 32'h0);
    pstrb <= 4'hf;
    rd(`MDK_IDX_KEY, 32'h7f00, "key byte strobe");
    `CHK("relock", 1'b0, cfg_unlocked)
    apb(1'b1, `MDK_IDX_KEY, 32'h1234);
    repeat (3) @(posedge clk);
    lock_key <= 15'h0abc;
    unl(1'b0, "lock key changed");
    lock_key <= 15'h0000;
    apb(1'b1, `MDK_IDX_KEY, 32'h0);
    unl(1'b0, "zero key");
    for (int v = 0; v <= 24; v++) begin
      vw(6'h00, {16'hffff, 16'(v)});
      rd(`MDK_IDX_STATE, {16'h0, 16'(v)}, "state");
    end
    vw(6'd35, 32'hdead_beef);
    ce <= 1'b0;
    vw(6'd35, 32'h1111_1111);
    ce <= 1'b1;
    apb(1'b1, `MDK_IDX_EST_ANG, 32'h0);
    `CHK("var write refused", 1'b1, rerr)
    rd(`MDK_IDX_EST_ANG, 32'hdead_beef, "var kept");
    apb(1'b0, 11'h195, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdata)
    vw(6'd1, 32'h0010_0000);
    for (int f = 1; f < 16; f++) begin
      mon(4'h0, 4'(f), 1'b1, 14'h194, 4 * f);
      mon(4'h0, 4'(f), 1'b0, 14'h194, 2048 + 2 * f);
    end
    mon(4'h3, 4'h1, 1'b1, 14'h194, 4);
    rd(`MDK_IDX_MON2, 32'h194, "pointer");
    vw(6'd1, 32'hfff0_0000);
    mon(4'h0, 4'h8, 1'b0, 14'h194, 2032);
    vw(6'd1, 32'h0800_0000);
    mon(4'h0, 4'h4, 1'b1, 14'h194, 2048);
    mon(4'h0, 4'hf, 1'b1, 14'h194, 4095);
    rd(`MDK_IDX_STAT, 32'h6, "status");
    apb(1'b1, `MDK_IDX_STAT, 32'h0);
    `CHK("status write refused", 1'b1, rerr)
    mon(4'h0, 4'h8, 1'b0, 14'h194, 4095);
    mon(4'h0, 4'h8, 1'b1, 14'h195, 0);
    vw(6'd1, 32'd5);
    for (int m = 0; m < 16; m++) begin
      mon(4'(m), 4'h0, 1'b1, 14'h194, 5 << m);
      mon(4'(m), 4'h0, 1'b0, 14'h194, 2048 + (5 << m));
    end
    vw(6'd1, 32'd40);
    mon(4'h0, 4'h0, 1'b1, 14'h194, 31);
    lock_key <= 15'h1234;
    apb(1'b1, `MDK_IDX_KEY, 32'h1234);
    unl(1'b1, "unlock again");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(`MDK_IDX_KEY, 32'h0, "key after reset");
    `CHK("locked after reset", 1'b0, cfg_unlocked)
    close_out();
  end
endmodule
`default_nettype wire
